// file: hdl/stf_pkg.sv
package stf_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W     = 8;
  localparam logic [7:0]  OFS_ROOT   = 8'h00;
  localparam logic [7:0]  OFS_MODE   = 8'h04;
  localparam logic [7:0]  OFS_BASE   = 8'h08;
  localparam logic [7:0]  OFS_BOUND  = 8'h0c;
  localparam logic [7:0]  OFS_STATUS = 8'h10;
  localparam logic [31:0] ROOT_RST   = 32'h0000_0000;
  localparam logic [31:0] BASE_RST   = 32'h0000_0000;
  localparam logic [31:0] BOUND_RST  = 32'h0000_0000;
  // ---------------------------------------------------------------
  // root register layout, page size
  // ---------------------------------------------------------------
  localparam int ROOT_ADDRESS_SPACE_ID_LSB = 22;
  localparam int ROOT_ADDRESS_SPACE_ID_MAX = 10;
  localparam int PAGE_BYTES    = 4096;
  localparam int PAGE_SHIFT    = $clog2(PAGE_BYTES);
  // ---------------------------------------------------------------
  // translation modes
  // ---------------------------------------------------------------
  localparam int         MODE_W       = 5;
  localparam logic [4:0] MODE_BARE    = 5'h00;
  localparam logic [4:0] MODE_BB      = 5'h01;
  localparam logic [4:0] MODE_BBID    = 5'h02;
  localparam logic [4:0] MODE_PAGED32 = 5'h08;
  localparam logic [4:0] MODE_RST     = MODE_BARE;
  // ---------------------------------------------------------------
  // fence encoding
  // ---------------------------------------------------------------
  localparam logic [6:0]  OPC_SYSTEM = 7'h73;
  localparam logic [2:0]  FN3_PRIVILEGED_FUNCTION_CODE   = 3'h0;
  localparam logic [11:0] FN12_FENCE = 12'h104;
  localparam logic [1:0]  PRIVILEGED_FUNCTION_CODE_USER  = 2'h0;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DRAIN,
    ST_FLUSH,
    ST_DONE
  } stf_state_t;
endpackage : stf_pkg

// file: hdl/stf_translation_fence.sv
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
// Functional notes
// [R1] root register holds root table page number and address_space_id
// [R2] root register exists only when paging is supported
// [R3] page-number bits beyond physical width read as zero
// [R4] address_space_id width is a parameter; only implemented bits read one
// [R5] one write updates page number and identifier together
// [R6] decode fence from 12-bit function, operand, privileged code, opcode
// [R7] prior stores drain before later implicit table references
// [R8] prior implicit table writes complete before later loads and stores
// [R9] fence invalidates affected local translation cache entries
// [R10] fence acts only on this hart
// [R11] nonzero identifier limits fence to current address space
// [R12] zero identifier flushes every address space, globals included
// [R13] zero_register operand covers all addresses and table levels
// [R14] other operand orders only the leaf table of that address
// [R15] a build option may always perform a full global fence
// [R16] bare mode passes truncated address straight through
// [R17] base-and-bounds modes relocate and bound-check addresses
// [R18] base page size is 4 KiB
// [R19] nonzero identifier may keep global mappings cached
// [R20] paged_32bit_scheme mode enables two-level paged translation
// [R21] fence from user privilege raises illegal instruction, does nothing
module stf_translation_fence
  import stf_pkg::*;
#(
  parameter int PPN_BITS   = 22,
  parameter int ADDRESS_SPACE_ID_BITS  = 10,
  parameter bit HAS_PAGING = 1'b1,
  parameter bit FULL_FENCE = 1'b0
) (
  input  wire logic                         clk_sys_in,
  input  wire logic                         reset_n_in,
  input  wire logic [stf_pkg::ADDR_W-1:0]   reg_addr_in,
  input  wire logic [31:0]                  reg_wdata_in,
  input  wire logic                         reg_wr_in,
  input  wire logic                         reg_rd_in,
  output logic      [31:0]                  reg_rdata_out,
  input  wire logic                         instr_valid_in,
  input  wire logic [31:0]                  instr_in,
  input  wire logic [1:0]                   privileged_function_code_in,
  input  wire logic [31:0]                  operand_value_in,
  input  wire logic                         store_drained_in,
  input  wire logic                         implicit_wr_idle_in,
  input  wire logic                         flush_ack_in,
  output logic                              fence_busy_out,
  output logic                              fence_done_out,
  output logic                              illegal_instr_out,
  output logic                              walker_hold_out,
  output logic                              flush_req_out,
  output logic                              flush_all_address_space_id_out,
  output logic                              flush_keep_global_out,
  output logic                              flush_all_va_out,
  output logic [ADDRESS_SPACE_ID_BITS-1:0]              flush_address_space_id_out,
  output logic [31-stf_pkg::PAGE_SHIFT:0]   flush_vpn_out,
  output logic                              paged_enable_out,
  output logic [PPN_BITS-1:0]               root_ppn_out,
  output logic [ADDRESS_SPACE_ID_BITS-1:0]              address_space_id_out,
  input  wire logic                         xlat_valid_in,
  input  wire logic [31:0]                  xlat_va_in,
  output logic                              xlat_valid_out,
  output logic [PPN_BITS+stf_pkg::PAGE_SHIFT-1:0] xlat_pa_out,
  output logic                              xlat_fault_out,
  output logic                              xlat_paged_out
);
  import stf_pkg::*;

  localparam int PA_BITS = PPN_BITS + PAGE_SHIFT;
  localparam logic [31:0] PPN_MASK = 32'((64'h1 << PPN_BITS) - 64'h1);
  localparam logic [31:0] ADDRESS_SPACE_ID_MASK =
    32'(((64'h1 << ADDRESS_SPACE_ID_BITS) - 64'h1) << ROOT_ADDRESS_SPACE_ID_LSB);
  localparam logic [31:0] ROOT_MASK =
    HAS_PAGING ? (PPN_MASK | ADDRESS_SPACE_ID_MASK) : 32'h0000_0000;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic is_fence(input logic [31:0] ins);
    is_fence = (ins[6:0] == OPC_SYSTEM) && (ins[14:12] == FN3_PRIVILEGED_FUNCTION_CODE) &&
               (ins[11:7] == 5'h00) && (ins[31:20] == FN12_FENCE); // R6
  endfunction : is_fence

  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [31:0]       root;
  logic [31:0]       next_root;
  logic [MODE_W-1:0] mode;
  logic [MODE_W-1:0] next_mode;
  logic [31:0]       base;
  logic [31:0]       next_base;
  logic [31:0]       bound;
  logic [31:0]       next_bound;

  always_comb
  begin
    next_root  = root;
    next_mode  = mode;
    next_base  = base;
    next_bound = bound;
    if (reg_wr_in)
    begin
      // whole pair in one store, masked to implemented bits
      if (hit(reg_addr_in, OFS_ROOT))
        next_root = reg_wdata_in & ROOT_MASK; // R1 R2 R3 R4 R5
      if (hit(reg_addr_in, OFS_MODE))
        next_mode = reg_wdata_in[MODE_W-1:0];
      if (hit(reg_addr_in, OFS_BASE))
        next_base = reg_wdata_in;
      if (hit(reg_addr_in, OFS_BOUND))
        next_bound = reg_wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      root  <= ROOT_RST;
      mode  <= MODE_RST;
      base  <= BASE_RST;
      bound <= BOUND_RST;
    end
    else
    begin
      root  <= next_root;
      mode  <= next_mode;
      base  <= next_base;
      bound <= next_bound;
    end
  end

  assign root_ppn_out = root[PPN_BITS-1:0];
  assign address_space_id_out     = root[ROOT_ADDRESS_SPACE_ID_LSB +: ADDRESS_SPACE_ID_BITS];
  // translation always reads both fields from the same flop word
  assign paged_enable_out = HAS_PAGING && (mode == MODE_PAGED32); // R20

  // ---------------------------------------------------------------
  // fence sequencer
  // ---------------------------------------------------------------
  stf_state_t                 state;
  stf_state_t                 next_state;
  logic                       all_address_space_id;
  logic                       next_all_address_space_id;
  logic                       all_va;
  logic                       next_all_va;
  logic [ADDRESS_SPACE_ID_BITS-1:0]       f_address_space_id;
  logic [ADDRESS_SPACE_ID_BITS-1:0]       next_f_address_space_id;
  logic [31-PAGE_SHIFT:0]     f_vpn;
  logic [31-PAGE_SHIFT:0]     next_f_vpn;
  logic                       illegal;
  logic                       next_illegal;
  logic                       fence_seen;

  assign fence_seen = instr_valid_in && is_fence(instr_in) &&
                      (state == ST_IDLE);

  always_comb
  begin
    next_state    = state;
    next_all_address_space_id = all_address_space_id;
    next_all_va   = all_va;
    next_f_address_space_id   = f_address_space_id;
    next_f_vpn    = f_vpn;
    next_illegal  = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (fence_seen && (privileged_function_code_in == PRIVILEGED_FUNCTION_CODE_USER))
          next_illegal = 1'b1; // R21
        else if (fence_seen)
        begin
          next_state    = ST_DRAIN;
          next_f_address_space_id   = address_space_id_out;
          next_all_address_space_id = FULL_FENCE || (address_space_id_out == '0); // R12 R15
          next_all_va   = FULL_FENCE ||
                          (instr_in[19:15] == 5'h00); // R13 R14 R15
          next_f_vpn    = operand_value_in[31:PAGE_SHIFT]; // R18
        end
      end
      ST_DRAIN:
      begin
        // stores and walker writes must land before tables are reused
        if (store_drained_in && implicit_wr_idle_in) // R7 R8
          next_state = ST_FLUSH;
      end
      ST_FLUSH:
      begin
        if (flush_ack_in) // R9
          next_state = ST_DONE;
      end
      ST_DONE:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state    <= ST_IDLE;
      all_address_space_id <= 1'b1;
      all_va   <= 1'b1;
      f_address_space_id   <= '0;
      f_vpn    <= '0;
      illegal  <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      all_address_space_id <= next_all_address_space_id;
      all_va   <= next_all_va;
      f_address_space_id   <= next_f_address_space_id;
      f_vpn    <= next_f_vpn;
      illegal  <= next_illegal;
    end
  end

  // local hart only: no request ever leaves toward other harts
  assign flush_req_out         = (state == ST_FLUSH); // R9 R10
  assign flush_all_address_space_id_out    = all_address_space_id; // R11 R12
  assign flush_keep_global_out = !all_address_space_id; // R19
  assign flush_all_va_out      = all_va; // R13 R14
  assign flush_address_space_id_out        = f_address_space_id;
  assign flush_vpn_out         = f_vpn;
  assign walker_hold_out       = (state != ST_IDLE); // R7
  assign fence_busy_out        = (state != ST_IDLE); // R8
  assign fence_done_out        = (state == ST_DONE);
  assign illegal_instr_out     = illegal;

  // ---------------------------------------------------------------
  // bare and base-and-bounds mapping
  // ---------------------------------------------------------------
  logic               xv;
  logic               next_xv;
  logic [PA_BITS-1:0] xpa;
  logic [PA_BITS-1:0] next_xpa;
  logic               xf;
  logic               next_xf;
  logic               xpg;
  logic               next_xpg;
  logic [32:0]        reloc;

  always_comb
  begin
    reloc    = {1'b0, xlat_va_in} + {1'b0, base};
    next_xv  = xlat_valid_in;
    next_xpa = '0;
    next_xf  = 1'b0;
    next_xpg = 1'b0;
    if (xlat_valid_in)
      case (mode)
        MODE_BB, MODE_BBID:
        begin
          // one pair serves fetch and data alike
          next_xpa = PA_BITS'(reloc); // R17
          next_xf  = (xlat_va_in >= bound) || reloc[32]; // R17
        end
        MODE_PAGED32:
          next_xpg = paged_enable_out; // R20
        default:
          next_xpa = PA_BITS'(xlat_va_in); // R16
      endcase
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      xv  <= 1'b0;
      xpa <= '0;
      xf  <= 1'b0;
      xpg <= 1'b0;
    end
    else
    begin
      xv  <= next_xv;
      xpa <= next_xpa;
      xf  <= next_xf;
      xpg <= next_xpg;
    end
  end

  assign xlat_valid_out = xv;
  assign xlat_pa_out    = xpa;
  assign xlat_fault_out = xf;
  assign xlat_paged_out = xpg;

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (reg_rd_in)
      case (reg_addr_in)
        OFS_ROOT:   next_rdata = root; // R3 R4
        OFS_MODE:   next_rdata = {27'h0, mode};
        OFS_BASE:   next_rdata = base;
        OFS_BOUND:  next_rdata = bound;
        OFS_STATUS: next_rdata = {29'h0, illegal, state};
        default:    next_rdata = 32'h0000_0000;
      endcase
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      rdata <= 32'h0000_0000;
    else
      rdata <= next_rdata;
  end

  assign reg_rdata_out = rdata;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence seq_fence_go;
    fence_seen && (privileged_function_code_in != PRIVILEGED_FUNCTION_CODE_USER);
  endsequence

  sequence seq_drained;
    store_drained_in && implicit_wr_idle_in;
  endsequence

  a_user_fence_trap: assert property ( // R21
    fence_seen && (privileged_function_code_in == PRIVILEGED_FUNCTION_CODE_USER)
      |=> illegal_instr_out && !fence_busy_out)
    else $error("user fence not trapped");

  a_hold_till_drain: assert property ( // R7
    seq_fence_go |=> walker_hold_out && !flush_req_out)
    else $error("walker not held during fence");

  a_flush_after_drain: assert property ( // R8
    $rose(flush_req_out) |-> $past(store_drained_in && implicit_wr_idle_in))
    else $error("flush before drain");

  a_flush_held: assert property ( // R9
    flush_req_out && !flush_ack_in |=> flush_req_out)
    else $error("flush request dropped");

  a_flush_done: assert property ( // R9
    flush_req_out && flush_ack_in |=> fence_done_out ##1 !fence_busy_out)
    else $error("fence did not finish");

  a_address_space_id_zero_all: assert property ( // R12
    flush_req_out && (flush_address_space_id_out == '0) |-> flush_all_address_space_id_out)
    else $error("zero identifier not global");

  a_address_space_id_scoped: assert property ( // R11
    seq_fence_go ##0 (address_space_id_out != '0) ##0 !FULL_FENCE
      |=> !flush_all_address_space_id_out && flush_keep_global_out)
    else $error("identifier scope lost");

  a_va_scope: assert property ( // R13
    seq_fence_go |=> flush_all_va_out ==
      (FULL_FENCE || ($past(instr_in) & 32'h000f_8000) == 32'h0))
    else $error("address scope wrong");

  a_root_masked: assert property ( // R3
    reg_rd_in && hit(reg_addr_in, OFS_ROOT) |=> ~|(reg_rdata_out & ~ROOT_MASK))
    else $error("unimplemented root bits read one");

  a_root_atomic: assert property ( // R5
    reg_wr_in && hit(reg_addr_in, OFS_ROOT)
      |=> {address_space_id_out, root_ppn_out} ==
          {$past(reg_wdata_in[ROOT_ADDRESS_SPACE_ID_LSB +: ADDRESS_SPACE_ID_BITS]) &
           ADDRESS_SPACE_ID_BITS'(ROOT_MASK >> ROOT_ADDRESS_SPACE_ID_LSB),
           $past(reg_wdata_in[PPN_BITS-1:0]) & PPN_BITS'(ROOT_MASK)})
    else $error("root fields not updated together");

  a_bare_map: assert property ( // R16
    xlat_valid_in && (mode == MODE_BARE)
      |=> xlat_valid_out && !xlat_fault_out &&
          xlat_pa_out == PA_BITS'($past(xlat_va_in)))
    else $error("bare address altered");

  a_bound_fault: assert property ( // R17
    xlat_valid_in && (mode == MODE_BB) && (xlat_va_in >= bound)
      |=> xlat_fault_out)
    else $error("bound not enforced");

endmodule : stf_translation_fence

// file: verif/stf_mem_model.sv
`timescale 1ns/10ps
module stf_mem_model (
  input  wire logic       clk_sys_in,
  input  wire logic       reset_n_in,
  input  wire logic       busy_in,
  input  wire logic       flush_req_in,
  input  wire logic [3:0] lag_in,
  output logic            store_drained_out,
  output logic            implicit_wr_idle_out,
  output logic            flush_ack_out
);
  logic [3:0] dcnt;
  logic [3:0] fcnt;
  logic [3:0] next_dcnt;
  logic [3:0] next_fcnt;
  // ---------------------------------------------------------------
  // drain and flush delays
  // ---------------------------------------------------------------
  // the walker idles one cycle after the store queue, so the two
  // inputs are not always seen together
  always_comb
  begin
    next_dcnt = busy_in ? dcnt + {3'h0, dcnt != 4'hf} : 4'h0;
    next_fcnt = flush_req_in ? fcnt + {3'h0, fcnt != 4'hf} : 4'h0;
  end
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      dcnt <= 4'h0;
      fcnt <= 4'h0;
    end
    else
    begin
      dcnt <= next_dcnt;
      fcnt <= next_fcnt;
    end
  end
  assign store_drained_out    = !busy_in || dcnt >= lag_in;
  assign implicit_wr_idle_out = !busy_in || dcnt > lag_in;
  assign flush_ack_out        = flush_req_in && fcnt >= lag_in;
endmodule : stf_mem_model

// file: verif/test_supervisor_translation_fence.sv
`timescale 1ns/10ps
module test_supervisor_translation_fence;
  import stf_pkg::*;
  localparam int PB = 20;
  localparam int AB = 6;
  logic clk_sys_in = 1'b0, reset_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, instr_valid_in = 1'b0;
  logic [31:0] instr_in = 32'h0, operand_value_in = 32'h0;
  logic [1:0] privileged_function_code_in = 2'h1;
  logic st_dr, wr_idle, ack, busy, done, ill, hold, freq, f_all_address_space_id;
  logic f_keep_g, f_all_va, paged_en, xv_out, x_fault, x_paged;
  logic [AB-1:0] f_address_space_id, address_space_id_o;
  logic [19:0] f_vpn;
  logic [PB-1:0] ppn_o;
  logic [31:0] x_pa;
  logic xlat_valid_in = 1'b0;
  logic [31:0] xlat_va_in = 32'h0;
  logic [3:0] lag = 4'h0;
  int seed = 32'h118c;
  int n_errors = 0, checked = 0;
  logic [31:0] rq[$], fq[$], e, base, bound, v, sc;
  logic [5:0] address_space_id_w;
  logic [34:0] xq[$], xe;
  logic rd_pend = 1'b0, xl_pend = 1'b0, seen_dr = 1'b0;
  logic [4:0] modes[4] = '{MODE_BARE, MODE_BB, MODE_BBID, MODE_PAGED32};
  logic [4:0] md;

  always #4 clk_sys_in = ~clk_sys_in;

  stf_translation_fence #(.PPN_BITS(PB), .ADDRESS_SPACE_ID_BITS(AB)) uut (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .instr_valid_in(instr_valid_in),
    .instr_in(instr_in), .privileged_function_code_in(privileged_function_code_in),
    .operand_value_in(operand_value_in), .store_drained_in(st_dr),
    .implicit_wr_idle_in(wr_idle), .flush_ack_in(ack),
    .fence_busy_out(busy), .fence_done_out(done),
    .illegal_instr_out(ill), .walker_hold_out(hold),
    .flush_req_out(freq), .flush_all_address_space_id_out(f_all_address_space_id),
    .flush_keep_global_out(f_keep_g), .flush_all_va_out(f_all_va),
    .flush_address_space_id_out(f_address_space_id), .flush_vpn_out(f_vpn),
    .paged_enable_out(paged_en), .root_ppn_out(ppn_o),
    .address_space_id_out(address_space_id_o), .xlat_valid_in(xlat_valid_in),
    .xlat_va_in(xlat_va_in), .xlat_valid_out(xv_out),
    .xlat_pa_out(x_pa), .xlat_fault_out(x_fault),
    .xlat_paged_out(x_paged));

  stf_mem_model mem (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .busy_in(busy),
    .flush_req_in(freq), .lag_in(lag), .store_drained_out(st_dr),
    .implicit_wr_idle_out(wr_idle), .flush_ack_out(ack));

  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] x);
    checked++;
    if (s !== x)
    begin
      n_errors++;
      $display("[ERR] %s exp %h seen %h", nm, x, s);
    end
  endtask : chk

  task end_sim;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    rq.push_back(x);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
  endtask : rd

  task automatic xl(input logic [31:0] va);
    @(posedge clk_sys_in);
    xlat_valid_in <= 1'b1;
    xlat_va_in    <= va;
    if (md == MODE_PAGED32)
      xq.push_back({2'b00, 1'b1, 32'h0});
    else if (md == MODE_BARE)
      xq.push_back({2'b10, 1'b0, va});
    else if (va >= bound)
      xq.push_back({2'b01, 1'b0, 32'h0});
    else
      xq.push_back({2'b10, 1'b0, va + base});
    @(posedge clk_sys_in);
    xlat_valid_in <= 1'b0;
  endtask : xl

  task automatic fence(input logic [4:0] rs, input logic [4:0] rdst,
                       input logic [31:0] opv, input logic [1:0] pv,
                       input logic [AB-1:0] address_space_id);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    instr_valid_in   <= 1'b1;
    instr_in         <= {FN12_FENCE, rs, FN3_PRIVILEGED_FUNCTION_CODE, rdst, OPC_SYSTEM};
    privileged_function_code_in          <= pv;
    operand_value_in <= opv;
    if (pv != PRIVILEGED_FUNCTION_CODE_USER && rdst == 5'h0)
      fq.push_back({3'h0, address_space_id == 0, address_space_id != 0, rs == 0, address_space_id, opv[31:12]});
    @(posedge clk_sys_in);
    instr_valid_in <= 1'b0;
    @(negedge clk_sys_in);
    if (pv == PRIVILEGED_FUNCTION_CODE_USER || rdst != 5'h0)
    begin
      chk("illegal", ill, pv == PRIVILEGED_FUNCTION_CODE_USER);
      chk("busy", busy, 0);
    end
    else
    begin
      while (!done && n < 60)
      begin
        @(negedge clk_sys_in);
        n++;
      end
      chk("done", done, 1);
    end
  endtask : fence

  // ---------------------------------------------------------------
  // result monitor
  // ---------------------------------------------------------------
  always @(posedge clk_sys_in)
  begin
    if (rd_pend && rq.size() > 0)
    begin
      e = rq.pop_front();
      chk("rdata", reg_rdata_out, e);
    end
    else if (reset_n_in)
      chk("rdata idle", reg_rdata_out, 32'h0);
    if (xl_pend && xq.size() > 0)
    begin
      xe = xq.pop_front();
      chk("xvalid", xv_out, 1);
      chk("fault", x_fault, xe[33]);
      chk("paged", x_paged, xe[32]);
      if (xe[34])
        chk("pa", x_pa, xe[31:0]);
    end
    else if (reset_n_in)
      chk("xvalid idle", xv_out, 0);
    if (freq && ack && fq.size() > 0)
    begin
      e = fq.pop_front();
      sc = {3'h0, f_all_address_space_id, f_keep_g, f_all_va, f_address_space_id, f_vpn};
      chk("scope", sc, e);
    end
    if (busy)
      chk("hold", hold, 1);
    if (freq)
      chk("drained", seen_dr, 1);
    seen_dr <= busy && (seen_dr || (st_dr && wr_idle));
    rd_pend <= reg_rd_in;
    xl_pend <= xlat_valid_in;
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    n_errors++;
    end_sim();
  end

  initial
  begin
    md = MODE_BARE;
    repeat (2) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    @(negedge clk_sys_in);
    chk("all_address_space_id", f_all_address_space_id, 1);
    chk("all_va", f_all_va, 1);
    chk("keep_g", f_keep_g, 0);
    rd(OFS_ROOT, ROOT_RST);
    rd(OFS_MODE, {27'h0, MODE_RST});
    rd(8'h20, 32'h0);
    wr(OFS_ROOT, 32'hffff_ffff);
    rd(OFS_ROOT, 32'h0fcf_ffff);
    chk("address_space_id", address_space_id_o, 6'h3f);
    chk("ppn", ppn_o, 20'hfffff);
    v = $random(seed);
    wr(OFS_ROOT, v);
    @(negedge clk_sys_in);
    chk("pair", {address_space_id_o, ppn_o}, {v[27:22], v[19:0]});
    base  = $random(seed) & 32'h0fff_f000;
    bound = $random(seed) & 32'h0fff_ffff;
    wr(OFS_BASE, base);
    wr(OFS_BOUND, bound);
    for (int m = 0; m < 4; m++)
    begin
      md = modes[m];
      wr(OFS_MODE, {27'h0, md});
      rd(OFS_MODE, {27'h0, md});
      chk("paged_en", paged_en, md == MODE_PAGED32);
      for (int k = 0; k < 4; k++)
        xl((k == 0) ? bound : $random(seed) & 32'h0fff_ffff);
    end
    for (int i = 0; i < 8; i++)
    begin
      lag = 4'($random(seed) & 7);
      v = {$random(seed)} % 63 + 1;
      address_space_id_w = i[1] ? v[5:0] : 6'h0;
      wr(OFS_ROOT, {4'h0, address_space_id_w, 22'h1});
      v = $random(seed) | 32'h1000;
      if (i[0])
        fence(5'h5, 5'h0, v, 2'h1, address_space_id_w);
      else
        fence(5'h0, 5'h0, 32'h0, 2'h3, address_space_id_w);
    end
    fence(5'h0, 5'h0, 32'h0, PRIVILEGED_FUNCTION_CODE_USER, 6'h0);
    fence(5'h0, 5'h1, 32'h0, 2'h1, 6'h0);
    rd(OFS_STATUS, 32'h0);
    // mid-run reset: scope, root and mode must all fall back
    repeat (2) @(posedge clk_sys_in);
    reset_n_in <= 1'b0;
    @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    @(negedge clk_sys_in);
    chk("all_address_space_id rst", f_all_address_space_id, 1);
    rd(OFS_ROOT, ROOT_RST);
    rd(OFS_MODE, {27'h0, MODE_RST});
    md = MODE_BARE;
    xl(32'h1234_5678);
    repeat (4) @(posedge clk_sys_in);
    chk("queues", fq.size() + rq.size() + xq.size(), 0);
    end_sim();
  end
endmodule : test_supervisor_translation_fence
